// [apfs_map.svh]
// constants for the auxiliary port function select block
// assumes six auxiliary ports and 16-bit result words
//
// Contract
// - ratiometric and absolute aux measurements coexist, each with own OV/UV thresholds
// - every aux result stored left-aligned as 14 bits in result bits 15:2
// - aux-configured port above supply is isolated and its protect flag set
// - protect fault and isolation hold until port function config is rewritten
// - summary flag is OR of the six per-port protect flags
// - general enable high makes the port general purpose regardless of aux enable
// - general enable low keeps the port's digital driver released
// - two-wire enable makes port 0 data and port 1 clock, overriding general enable
// - two-wire enable resets to zero
// - direction 0 is input with weak pulldown, 1 is output
// - output ports drive the level of their drive-level bit
// - two-wire enabled: results 0 and 1 read zero, their config bits ignored functionally
// - level readback shows actual pin level for input or output ports
// - aux ports read level 0; two-wire enabled reads bits 1:0 as 00
`ifndef APFS_MAP_SVH
`define APFS_MAP_SVH
`define APFS_PORTS       6
`define APFS_RES_W       16
`define APFS_ADC_W       14
`define APFS_RES_LSB     2
`define APFS_SDA_PORT    0
`define APFS_SCL_PORT    1
`define APFS_CFG_RESET   6'h00
`define APFS_RES_ZERO    16'h0000
`endif

// [apfs_pkg.sv]
// types for the auxiliary port function select block
// assumes apfs_map.svh is on the include path
`include "apfs_map.svh"
package apfs_pkg;
  typedef logic [`APFS_PORTS-1:0] apfs_port_vec_t;
  typedef logic [`APFS_RES_W-1:0] apfs_result_t;
  typedef enum logic [2:0]
  {
    APFS_FN_AUX     = 3'b001,
    APFS_FN_GENERAL = 3'b010,
    APFS_FN_TWOWIRE = 3'b100
  } apfs_func_t;
endpackage

// [apfs_port_select.sv]
// auxiliary port function select: aux / general purpose / two-wire muxing,
// overvoltage protect latching and level readback
// assumes analog comparators supply per-port overvoltage levels and the adc
// hands 14-bit results with one write strobe and a 3-bit port number; twowire core is outside
`timescale 1ns/100ps
`default_nettype none
`include "apfs_map.svh"
module apfs_port_select
  import apfs_pkg::*;
(
  input  wire logic                  clk_in,                    // 25 MHz clock
  input  wire logic                  rst_n_in,                  // sync reset, low
  input  wire logic                  clk_en_in,                 // freezes state when low
  input  wire logic                  cfg_write_in,              // config register write pulse
  input  wire logic [`APFS_PORTS-1:0] aux_measure_enable_in,    // aux measurement enables
  input  wire logic [`APFS_PORTS-1:0] aux_reference_select_in,  // 1 absolute, 0 ratiometric
  input  wire logic [`APFS_PORTS-1:0] port_general_enable_in,   // written general enables
  input  wire logic [`APFS_PORTS-1:0] port_direction_in,        // written directions
  input  wire logic                  twowire_controller_enable_in, // written two-wire enable
  input  wire logic                  level_write_in,            // drive level write pulse
  input  wire logic [`APFS_PORTS-1:0] port_drive_level_in,      // written drive levels
  input  wire logic [`APFS_PORTS-1:0] pin_level_in,             // pad input levels
  input  wire logic [`APFS_PORTS-1:0] overvoltage_in,           // pad above analog supply
  input  wire logic                  adc_valid_in,              // adc result strobe
  input  wire logic [2:0]            adc_port_in,               // port of adc result
  input  wire logic [`APFS_ADC_W-1:0] adc_data_in,              // 14-bit adc result
  input  wire logic                  sda_oe_n_in,               // twowire core data pull, low
  input  wire logic                  scl_oe_n_in,               // twowire core clock pull, low
  output var  logic [`APFS_PORTS-1:0] port_general_enable_out,  // read back
  output var  logic [`APFS_PORTS-1:0] port_direction_out,       // read back
  output var  logic [`APFS_PORTS-1:0] port_drive_level_out,     // read back
  output var  logic                  twowire_controller_enable_out, // read back
  output var  logic [`APFS_PORTS-1:0] aux_measure_enable_out,   // read back
  output var  logic [`APFS_PORTS-1:0] aux_reference_select_out, // read back
  output var  logic [`APFS_PORTS-1:0] port_level_readback_out,  // level readback
  output var  logic [`APFS_PORTS-1:0] aux_overvoltage_protect_flag_out, // sticky flags
  output var  logic                  aux_protect_summary_flag_out, // failure status summary
  output var  logic [`APFS_PORTS-1:0] aux_isolate_out,          // open-circuit aux input
  output var  logic [`APFS_PORTS-1:0] pin_out,                  // pad drive value
  output var  logic [`APFS_PORTS-1:0] pin_oe_n_out,             // pad enable, low drives
  output var  logic [`APFS_PORTS-1:0] pulldown_out,             // weak pulldown on
  output var  logic [`APFS_PORTS-1:0] abs_ref_out,              // absolute reference on
  output var  logic [`APFS_PORTS-1:0] abs_thresh_sel_out,       // absolute threshold set
  output var  logic [`APFS_PORTS*`APFS_RES_W-1:0] aux_result_out, // result words
  output var  logic [`APFS_PORTS-1:0] sda_sync_out,             // synced pin bits to core
  output var  logic                  sda_in_out,                // synced data line
  output var  logic                  scl_in_out                 // synced clock line
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic apfs_func_t port_func(input logic tw_en, input logic gen_en,
                                           input int idx);
    if (tw_en && (idx == `APFS_SDA_PORT || idx == `APFS_SCL_PORT))
      return APFS_FN_TWOWIRE;
    else if (gen_en)
      return APFS_FN_GENERAL;
    else
      return APFS_FN_AUX;
  endfunction

  logic [`APFS_PORTS-1:0] gen_en_reg;
  logic [`APFS_PORTS-1:0] dir_reg;
  logic [`APFS_PORTS-1:0] drv_reg;
  logic                   tw_en_reg;
  logic [`APFS_PORTS-1:0] aux_en_reg;
  logic [`APFS_PORTS-1:0] ref_sel_reg;
  logic [`APFS_PORTS-1:0] flag_reg;
  logic [`APFS_PORTS-1:0] flag_next;
  logic [`APFS_PORTS-1:0] sync1_reg;
  logic [`APFS_PORTS-1:0] sync2_reg;
  logic [`APFS_PORTS-1:0] sync3_reg;
  logic [`APFS_PORTS-1:0] stable_reg;
  logic [`APFS_PORTS-1:0] ov1_reg;
  logic [`APFS_PORTS-1:0] ov2_reg;
  logic [`APFS_PORTS-1:0] ov3_reg;
  logic [`APFS_PORTS-1:0] is_aux;
  logic [`APFS_PORTS-1:0] is_gen;
  logic [`APFS_PORTS-1:0] is_tw;
  logic [`APFS_PORTS-1:0] oe_n_next;
  logic [`APFS_PORTS-1:0] rd_next;
  apfs_result_t           res_reg [`APFS_PORTS];

  ////////////////////////////////////////////////////////////////////////////
  // per-port function decode and pad control
  genvar g;
  generate
    for (g = 0; g < `APFS_PORTS; g++)
    begin : g_port
      apfs_func_t fn;
      assign fn = port_func(tw_en_reg, gen_en_reg[g], g);
      assign is_tw[g]  = (fn == APFS_FN_TWOWIRE);
      assign is_gen[g] = (fn == APFS_FN_GENERAL);
      assign is_aux[g] = (fn == APFS_FN_AUX);
      assign oe_n_next[g] = is_tw[g] ? ((g == `APFS_SDA_PORT) ? sda_oe_n_in : scl_oe_n_in)
                          : !(is_gen[g] && dir_reg[g]);
      assign rd_next[g] = is_gen[g] & stable_reg[g];
      // overvoltage sets only while aux; set wins over a simultaneous rewrite
      assign flag_next[g] = (is_aux[g] && ov3_reg[g] == ov2_reg[g] && ov2_reg[g])
                          | (flag_reg[g] & ~cfg_write_in);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers, read back as written
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      gen_en_reg  <= `APFS_CFG_RESET;
      dir_reg     <= `APFS_CFG_RESET;
      drv_reg     <= `APFS_CFG_RESET;
      tw_en_reg   <= 1'b0;
      aux_en_reg  <= `APFS_CFG_RESET;
      ref_sel_reg <= `APFS_CFG_RESET;
    end
    else if (clk_en_in)
    begin
      if (cfg_write_in)
      begin
        gen_en_reg  <= port_general_enable_in;
        dir_reg     <= port_direction_in;
        tw_en_reg   <= twowire_controller_enable_in;
        aux_en_reg  <= aux_measure_enable_in;
        ref_sel_reg <= aux_reference_select_in;
      end
      if (level_write_in)
        drv_reg <= port_drive_level_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // three-stage input capture, change accepted when stages 2 and 3 agree
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      sync1_reg  <= `APFS_CFG_RESET;
      sync2_reg  <= `APFS_CFG_RESET;
      sync3_reg  <= `APFS_CFG_RESET;
      stable_reg <= `APFS_CFG_RESET;
      ov1_reg    <= `APFS_CFG_RESET;
      ov2_reg    <= `APFS_CFG_RESET;
      ov3_reg    <= `APFS_CFG_RESET;
    end
    else if (clk_en_in)
    begin
      sync1_reg <= pin_level_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      stable_reg <= (sync2_reg & sync3_reg) | (stable_reg & (sync2_reg | sync3_reg));
      ov1_reg <= overvoltage_in;
      ov2_reg <= ov1_reg;
      ov3_reg <= ov2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection flags, pad drive, readback
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      flag_reg                     <= `APFS_CFG_RESET;
      aux_protect_summary_flag_out <= 1'b0;
      pin_oe_n_out                 <= {`APFS_PORTS{1'b1}};
      pin_out                      <= `APFS_CFG_RESET;
      pulldown_out                 <= `APFS_CFG_RESET;
      port_level_readback_out      <= `APFS_CFG_RESET;
      sda_in_out                   <= 1'b1;
      scl_in_out                   <= 1'b1;
    end
    else if (clk_en_in)
    begin
      flag_reg                     <= flag_next;
      aux_protect_summary_flag_out <= |flag_next;
      pin_oe_n_out                 <= oe_n_next;
      pin_out                      <= drv_reg & is_gen;
      pulldown_out                 <= is_gen & ~dir_reg;
      port_level_readback_out      <= rd_next;
      sda_in_out                   <= stable_reg[`APFS_SDA_PORT];
      scl_in_out                   <= stable_reg[`APFS_SCL_PORT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result words, 14-bit value left-aligned; twowire ports read zero
  generate
    for (g = 0; g < `APFS_PORTS; g++)
    begin : g_res
      always_ff @(posedge clk_in)
      begin
        if (!rst_n_in)
          res_reg[g] <= `APFS_RES_ZERO;
        else if (clk_en_in && adc_valid_in && adc_port_in == 3'(g))
          res_reg[g] <= {adc_data_in, {`APFS_RES_LSB{1'b0}}};
      end
      always_ff @(posedge clk_in)
      begin
        if (!rst_n_in)
          aux_result_out[g*`APFS_RES_W +: `APFS_RES_W] <= `APFS_RES_ZERO;
        else if (clk_en_in)
          aux_result_out[g*`APFS_RES_W +: `APFS_RES_W] <=
            is_tw[g] ? `APFS_RES_ZERO : res_reg[g];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // registered mirrors of configuration and aux control
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      port_general_enable_out       <= `APFS_CFG_RESET;
      port_direction_out            <= `APFS_CFG_RESET;
      port_drive_level_out          <= `APFS_CFG_RESET;
      twowire_controller_enable_out <= 1'b0;
      aux_measure_enable_out        <= `APFS_CFG_RESET;
      aux_reference_select_out      <= `APFS_CFG_RESET;
      aux_isolate_out               <= `APFS_CFG_RESET;
      abs_ref_out                   <= `APFS_CFG_RESET;
      abs_thresh_sel_out            <= `APFS_CFG_RESET;
      aux_overvoltage_protect_flag_out <= `APFS_CFG_RESET;
      sda_sync_out                  <= `APFS_CFG_RESET;
    end
    else if (clk_en_in)
    begin
      port_general_enable_out       <= gen_en_reg;
      port_direction_out            <= dir_reg;
      port_drive_level_out          <= drv_reg;
      twowire_controller_enable_out <= tw_en_reg;
      aux_measure_enable_out        <= aux_en_reg;
      aux_reference_select_out      <= ref_sel_reg;
      aux_isolate_out               <= flag_next | ~is_aux;
      abs_ref_out                   <= ref_sel_reg & aux_en_reg & is_aux;
      abs_thresh_sel_out            <= ref_sel_reg;
      aux_overvoltage_protect_flag_out <= flag_next;
      sda_sync_out                  <= stable_reg;
    end
  end

endmodule
`default_nettype wire

// [apfs_port_select_properties.sv]
// checker: timing and value relations at the port select boundary
// assumes bind onto apfs_port_select with clk_en_in held high
`timescale 1ns/100ps
`default_nettype none
`include "apfs_map.svh"
module apfs_port_select_properties
  import apfs_pkg::*;
(
  input wire logic                                 clk_in,                           // clock
  input wire logic                                 rst_n_in,                         // reset
  input wire logic                                 cfg_write_in,                     // strobe
  input wire logic                                 adc_valid_in,                     // strobe
  input wire logic [2:0]                           adc_port_in,                      // port
  input wire logic [`APFS_ADC_W-1:0]               adc_data_in,                      // word
  input wire logic [`APFS_PORTS-1:0]               port_general_enable_out,          // mirror
  input wire logic [`APFS_PORTS-1:0]               port_direction_out,               // mirror
  input wire logic [`APFS_PORTS-1:0]               port_drive_level_out,             // mirror
  input wire logic                                 twowire_controller_enable_out,    // mirror
  input wire logic [`APFS_PORTS-1:0]               port_level_readback_out,          // levels
  input wire logic [`APFS_PORTS-1:0]               aux_overvoltage_protect_flag_out, // flags
  input wire logic                                 aux_protect_summary_flag_out,     // summary
  input wire logic [`APFS_PORTS-1:0]               aux_isolate_out,                  // isolate
  input wire logic [`APFS_PORTS-1:0]               pin_out,                          // drive
  input wire logic [`APFS_PORTS-1:0]               pin_oe_n_out,                     // enable
  input wire logic [`APFS_PORTS*`APFS_RES_W-1:0]   aux_result_out                    // results
);
  wire logic [`APFS_PORTS-1:0] ovf = aux_overvoltage_protect_flag_out;
  wire logic                   tw  = twowire_controller_enable_out;
  wire logic [`APFS_PORTS-1:0] fmask = tw ? 6'h3C : 6'h3F;
  wire logic [`APFS_PORTS-1:0] gen = port_general_enable_out & fmask;
  wire logic [`APFS_PORTS-1:0] osel = gen & port_direction_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////////////////////
  a_summary_or: assert property ($rose(|ovf) |-> ##[0:1] aux_protect_summary_flag_out)
    else $error("summary flag missed a port flag");
  a_summary_idle: assert property ((ovf == 6'h00) [*2] |-> !aux_protect_summary_flag_out)
    else $error("summary flag without port flag");
  a_flag_isolate: assert property (((ovf & $past(ovf) & ~aux_isolate_out) == 6'h00))
    else $error("flagged port not isolated");
  a_flag_sticky: assert property ((($past(ovf) & ~ovf) != 6'h00) |->
    ($past(cfg_write_in) || $past(cfg_write_in, 2) || $past(cfg_write_in, 3)))
    else $error("protect flag cleared without config write");
  a_result_align: assert property (adc_valid_in && adc_port_in > 3'h1 && adc_port_in < 3'h6
    |-> ##2 aux_result_out[$past(adc_port_in, 2)*16 +: 16] == {$past(adc_data_in, 2), 2'b00})
    else $error("result word not left aligned");
  a_twowire_result: assert property (tw && $past(tw) |-> aux_result_out[31:0] == 32'h0000_0000)
    else $error("two-wire port result not zero");
  a_twowire_level: assert property (tw && $past(tw) |-> port_level_readback_out[1:0] == 2'h0)
    else $error("two-wire port level not zero");
  a_general_release: assert property (((~port_general_enable_out & fmask & ~pin_oe_n_out) == 6'h00))
    else $error("driver enabled on non general port");
  a_output_drive: assert property (((pin_oe_n_out | (pin_out ^ port_drive_level_out)) & osel) == 6'h00)
    else $error("output port not driving its level");
  a_aux_level: assert property ((~gen & $past(~gen) & fmask & port_level_readback_out) == 6'h00)
    else $error("aux port level readback not zero");
  c_protect: cover property ($rose(aux_protect_summary_flag_out));
  c_twowire: cover property (tw && $past(tw));
  c_adc_top: cover property (adc_valid_in && adc_port_in == 3'h5);
endmodule
`default_nettype wire

// [apfs_pad_model.sv]
// pad model: resolves each auxiliary pad from chip drive, outside driver and pulldown
// assumes one clock; undriven pads wander instead of holding a level
`timescale 1ns/100ps
`default_nettype none
module apfs_pad_model
  import apfs_pkg::*;
(
  input  wire logic           clk_in,        // clock for idle pattern
  input  wire apfs_port_vec_t drive_in,      // chip drive value
  input  wire apfs_port_vec_t drive_oe_n_in, // low when chip drives
  input  wire apfs_port_vec_t pulldown_in,   // weak pulldown on
  input  wire apfs_port_vec_t ext_en_in,     // outside driver on
  input  wire apfs_port_vec_t ext_val_in,    // outside driver level
  output wire apfs_port_vec_t level_out      // resolved pad level
);
  apfs_port_vec_t idle_reg = 6'h2A;
  always_ff @(posedge clk_in)
    idle_reg <= ~idle_reg;
  // chip drive wins, then outside driver, then pulldown, else wander
  assign level_out = (~drive_oe_n_in & drive_in) | (drive_oe_n_in & ext_en_in & ext_val_in)
                   | (drive_oe_n_in & ~ext_en_in & ~pulldown_in & idle_reg);
endmodule
`default_nettype wire

// [apfs_port_select_test.sv]
// testbench for apfs_port_select with a pad model on the far side
// assumes apfs_map.svh on the include path; clk_en_in high except in the freeze scenario
`timescale 1ns/100ps
`default_nettype none
`include "apfs_map.svh"
`define CHK(a, b) check_eq((a), (b))
module apfs_port_select_test
  import apfs_pkg::*;
;
  logic clk_in, rst_n_in, clk_en_in, cfg_write_in, twowire_controller_enable_in, level_write_in;
  logic adc_valid_in, sda_oe_n_in, scl_oe_n_in, twowire_controller_enable_out;
  logic aux_protect_summary_flag_out, sda_in_out, scl_in_out;
  logic [2:0] adc_port_in;
  logic [13:0] adc_data_in;
  logic [95:0] aux_result_out;
  apfs_port_vec_t aux_measure_enable_in, aux_reference_select_in, port_general_enable_in;
  apfs_port_vec_t port_direction_in, port_drive_level_in, pin_level_in, overvoltage_in;
  apfs_port_vec_t port_general_enable_out, port_direction_out, port_drive_level_out;
  apfs_port_vec_t aux_measure_enable_out, aux_reference_select_out, port_level_readback_out;
  apfs_port_vec_t aux_overvoltage_protect_flag_out, aux_isolate_out, pin_out, pin_oe_n_out;
  apfs_port_vec_t pulldown_out, abs_ref_out, abs_thresh_sel_out, sda_sync_out, ext_en, ext_val;
  int fail_count = 0;
  int checks_done = 0;
  apfs_port_select uut (.*);
  apfs_pad_model pads (.clk_in(clk_in), .drive_in(pin_out), .drive_oe_n_in(pin_oe_n_out),
    .pulldown_in(pulldown_out), .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pin_level_in));
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_eq(input logic [95:0] got, input logic [95:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic cfg(input apfs_port_vec_t gen, dir, aux, refs, input logic tw);
    {port_general_enable_in, port_direction_in, aux_measure_enable_in} = {gen, dir, aux};
    aux_reference_select_in = refs;
    twowire_controller_enable_in = tw;
    cfg_write_in = 1'b1;
    cyc(1);
    cfg_write_in = 1'b0;
    cyc(3);
  endtask
  task automatic pulse_level(input logic [1:0] sel, input apfs_port_vec_t v, input logic [2:0] p);
    {port_drive_level_in, adc_port_in, adc_data_in} = {v, p, 8'h00, v};
    {level_write_in, adc_valid_in} = sel;
    cyc(1);
    {level_write_in, adc_valid_in} = 2'b00;
    cyc(3);
  endtask
  task automatic t_output;
    cfg(6'h3F, 6'h3F, 6'h00, 6'h00, 1'b0);
    pulse_level(2'b10, 6'h2D, 3'h0);
    `CHK(pin_oe_n_out, 6'h00);
    `CHK(pin_out, 6'h2D);
    cyc(6);
    `CHK(port_level_readback_out, 6'h2D);
  endtask
  task automatic t_input;
    {ext_en, ext_val} = {6'h3F, 6'h15};
    cfg(6'h3F, 6'h00, 6'h3F, 6'h00, 1'b0);
    cyc(6);
    `CHK({pulldown_out, pin_oe_n_out}, 12'hFFF);
    `CHK(port_level_readback_out, 6'h15);
    ext_en = 6'h00;
    cyc(6);
    `CHK(port_level_readback_out, 6'h00);
  endtask
  task automatic t_aux;
    cfg(6'h00, 6'h00, 6'h3F, 6'h0A, 1'b0);
    pulse_level(2'b01, 6'h3F, 3'h3);
    `CHK(aux_result_out[63:48], 16'h00FC);
    `CHK({aux_measure_enable_out, aux_reference_select_out}, 12'hFCA);
    `CHK({abs_ref_out, abs_thresh_sel_out}, 12'h28A);
    `CHK({port_level_readback_out, pin_oe_n_out}, 12'h03F);
    overvoltage_in = 6'h04;
    cyc(8);
    overvoltage_in = 6'h00;
    cyc(8);
    `CHK(aux_overvoltage_protect_flag_out, 6'h04);
    `CHK({aux_isolate_out[2], aux_protect_summary_flag_out}, 2'b11);
    cfg(6'h01, 6'h00, 6'h3F, 6'h0A, 1'b0);
    `CHK({aux_overvoltage_protect_flag_out, aux_isolate_out[2]}, 7'h00);
    overvoltage_in = 6'h01;
    cyc(8);
    `CHK(aux_overvoltage_protect_flag_out, 6'h00);
    overvoltage_in = 6'h00;
  endtask
  task automatic t_twowire;
    {ext_en, ext_val} = {6'h02, 6'h02};
    cfg(6'h3F, 6'h3F, 6'h3F, 6'h00, 1'b1);
    sda_oe_n_in = 1'b0;
    pulse_level(2'b11, 6'h3F, 3'h1);
    cyc(6);
    `CHK({port_general_enable_out, port_direction_out, port_drive_level_out}, 18'h3FFFF);
    `CHK({twowire_controller_enable_out, aux_result_out[31:0]}, 33'h1_0000_0000);
    `CHK({pin_oe_n_out[1:0], pin_out[0]}, 3'b100);
    `CHK(port_level_readback_out, 6'h3C);
    `CHK({sda_in_out, scl_in_out, sda_sync_out}, 8'h7E);
  endtask
  task automatic t_freeze;
    clk_en_in = 1'b0;
    pulse_level(2'b10, 6'h00, 3'h0);
    `CHK({port_drive_level_out, pin_out}, 12'hFFC);
    clk_en_in = 1'b1;
    cyc(2);
    `CHK({port_drive_level_out, pin_out}, 12'hFFC);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    {rst_n_in, cfg_write_in, twowire_controller_enable_in, level_write_in, adc_valid_in} = 5'h00;
    {clk_en_in, sda_oe_n_in, scl_oe_n_in, adc_port_in, adc_data_in} = {3'b111, 17'h00000};
    {aux_measure_enable_in, aux_reference_select_in, port_general_enable_in} = 18'h00000;
    {port_direction_in, port_drive_level_in, overvoltage_in, ext_en, ext_val} = 30'h0;
    cyc(4);
    rst_n_in = 1'b1;
    `CHK({twowire_controller_enable_out, pin_oe_n_out}, 7'h3F);
    t_output();
    t_input();
    t_aux();
    t_twowire();
    t_freeze();
    test_done();
  end
  initial
  begin
    #(2000 * 40);
    fail_count++;
    test_done();
  end
endmodule
bind apfs_port_select apfs_port_select_properties chk (.*);
`default_nettype wire
